// file: hw/efsr_fifo_mem.sv
// 16-entry byte fifo with occupancy count
// assumes caller never pushes when full nor pops when empty
`timescale 1ns/100ps
`default_nettype none
module efsr_fifo_mem
   import efsr_pkg::*;
#(
   parameter int DEPTH = EFSR_DEPTH,
   parameter int DW = EFSR_DATA_W
)
(
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_b_in,
   input wire logic flush_in,
   // push and pop
   input wire logic push_in,
   input wire logic [DW-1:0] wdata_in,
   input wire logic pop_in,
   output logic [DW-1:0] rdata_out,
   output logic [EFSR_CNT_W-1:0] count_out
);
   // pointers are four bits wide, so only a 16-deep store is served
   if (DEPTH != 16)
   begin : g_depth_chk
      $error("fifo depth must be 16");
   end
   logic [DW-1:0] mem_r [DEPTH];
   logic [3:0] wp_r;
   logic [3:0] rp_r;
   always_ff @(posedge sys_clk_in)
   begin
      if (push_in)
         mem_r[wp_r] <= wdata_in;
   end
   always_ff @(posedge sys_clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         wp_r <= 4'h0;
         rp_r <= 4'h0;
         count_out <= 5'h00;
      end
      else if (flush_in)
      begin
         wp_r <= 4'h0;
         rp_r <= 4'h0;
         count_out <= 5'h00;
      end
      else
      begin
         // shared count moves on a lone push or pop, holds when both come together
         if (push_in)
            wp_r <= wp_r + 4'h1;
         if (pop_in)
            rp_r <= rp_r + 4'h1;
         if (push_in && !pop_in)
            count_out <= count_out + 5'h01;
         else if (pop_in && !push_in)
            count_out <= count_out - 5'h01;
      end
   end
   assign rdata_out = mem_r[rp_r];
endmodule : efsr_fifo_mem
`default_nettype wire

// file: hw/efsr_sync.sv
// two-flop synchroniser for one pin level
// assumes the pin is asynchronous to sys_clk_in
`timescale 1ns/100ps
`default_nettype none
module efsr_sync
   import efsr_pkg::*;
#(
   parameter logic RST_VAL = 1'b0
)
(
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_b_in,
   // level
   input wire logic pin_in,
   output logic sync_out
);
   logic meta_r;
   always_ff @(posedge sys_clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         meta_r <= RST_VAL;
         sync_out <= RST_VAL;
      end
      else
      begin
         meta_r <= pin_in;
         sync_out <= meta_r;
      end
   end
endmodule : efsr_sync
`default_nettype wire

// file: hw/efsr_top.sv
// fifo service-request logic of the extended parallel port
// Function
// - dma only against data, test, compatible fifos
// - request each dma transfer on dma request
// - terminal count raises interrupt, sets mask
// - max 32 dma cycles, then 350ns gap
// - dma cycles select fifo by acknowledge only
// - reverse: request while data, drop empty/tc
// - last byte drops request at ack or read
// - emptied request returns with one byte
// - tc request returns only after mask cleared
// - pio decode 400h data, 000h address fifo
// - pio service via port interrupt output
// - threshold 16 treated as 15
// - reverse irq when count >= 16-threshold
// - forward irq when count <= threshold
// - test mode exposes fifo through data port
// - threshold field holds threshold minus one
// - mask set blocks dma and service irq
// - interrupt is brief low pulse, then release
// - fifo disabled after reset until mode
// assumes isa strobes asynchronous, protocol engine on sys_clk_in
`timescale 1ns/100ps
`default_nettype none
module efsr_top
   import efsr_pkg::*;
#(
   parameter int BURST_MAX = EFSR_BURST_MAX,
   parameter int GAP_CYC = EFSR_DACK_GAP_CYC
)
(
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_b_in,
   // isa host pins
   input wire logic [EFSR_ADDR_W-1:0] host_addr_in,
   input wire logic host_ior_n_in,
   input wire logic host_iow_n_in,
   input wire logic [EFSR_DATA_W-1:0] host_wdata_in,
   output logic [EFSR_DATA_W-1:0] host_rdata_out,
   output logic host_rdata_oe_n_out,
   input wire logic port_dma_acknowledge_n_in,
   input wire logic host_tc_in,
   output logic port_dma_request_out,
   output logic port_irq_line_out,
   output logic port_irq_line_oe_n_out,
   // control levels
   input wire logic [2:0] port_mode_in,
   input wire logic direction_in,
   input wire logic dma_enable_bit_in,
   input wire logic service_interrupt_mask_in,
   input wire logic [3:0] threshold_field_in,
   // status
   output logic service_interrupt_set_out,
   output logic [EFSR_CNT_W-1:0] fifo_count_out,
   // protocol engine side
   input wire logic eng_pop_in,
   output logic [EFSR_DATA_W-1:0] eng_data_out,
   output logic eng_is_addr_out,
   input wire logic eng_push_in,
   input wire logic [EFSR_DATA_W-1:0] eng_data_in
);
   // six-bit burst and gap counters bound both counts
   if (BURST_MAX < 1 || BURST_MAX > 63 || GAP_CYC < 1 || GAP_CYC > 63)
   begin : g_param_chk
      $error("burst or gap count out of range");
   end
   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   logic ior_n_s;
   logic iow_n_s;
   logic dack_n_s;
   logic tc_s;
   efsr_sync #(.RST_VAL(1'b1)) u_ior (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
      .pin_in(host_ior_n_in), .sync_out(ior_n_s));
   efsr_sync #(.RST_VAL(1'b1)) u_iow (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
      .pin_in(host_iow_n_in), .sync_out(iow_n_s));
   efsr_sync #(.RST_VAL(1'b1)) u_dack (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
      .pin_in(port_dma_acknowledge_n_in), .sync_out(dack_n_s));
   efsr_sync #(.RST_VAL(1'b0)) u_tc (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
      .pin_in(host_tc_in), .sync_out(tc_s));
   // strobes delayed one more cycle to find their edges; isa holds address and data stable
   logic ior_n_d_r;
   logic iow_n_d_r;
   logic dack_n_d_r;
   always_ff @(posedge sys_clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         ior_n_d_r <= 1'b1;
         iow_n_d_r <= 1'b1;
         dack_n_d_r <= 1'b1;
      end
      else
      begin
         ior_n_d_r <= ior_n_s;
         iow_n_d_r <= iow_n_s;
         dack_n_d_r <= dack_n_s;
      end
   end
   // address and data take the same two-flop delay as the strobes;
   // safe only because the host holds them across the strobe edge
   logic [EFSR_ADDR_W-1:0] addr_m_r;
   logic [EFSR_ADDR_W-1:0] addr_s_r;
   logic [EFSR_DATA_W-1:0] wdata_m_r;
   logic [EFSR_DATA_W-1:0] wdata_s_r;
   always_ff @(posedge sys_clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         addr_m_r <= 11'h000;
         addr_s_r <= 11'h000;
         wdata_m_r <= 8'h00;
         wdata_s_r <= 8'h00;
      end
      else
      begin
         addr_m_r <= host_addr_in;
         addr_s_r <= addr_m_r;
         wdata_m_r <= host_wdata_in;
         wdata_s_r <= wdata_m_r;
      end
   end
   wire logic rd_fall = ior_n_d_r && !ior_n_s;
   wire logic wr_rise = !iow_n_d_r && iow_n_s;
   wire logic dack_fall = dack_n_d_r && !dack_n_s;
   // ------------------------------------------------------------
   // decode
   // ------------------------------------------------------------
   wire logic fifo_mode = (port_mode_in == EFSR_MODE_ECP) || (port_mode_in == EFSR_MODE_COMPATIBLE_MODE_FIFO)
      || (port_mode_in == EFSR_MODE_TEST);
   wire logic test_mode = (port_mode_in == EFSR_MODE_TEST);
   wire logic dma_cyc = !dack_n_s;
   wire logic dma_ok = fifo_mode && dma_enable_bit_in;
   // dma cycle picks the fifo without looking at the address
   wire logic sel_d = dma_cyc ? dma_ok : (addr_s_r == EFSR_DFIFO_OFS);
   wire logic sel_a = !dma_cyc && (addr_s_r == EFSR_AFIFO_OFS)
      && (port_mode_in == EFSR_MODE_ECP);
   logic [EFSR_CNT_W-1:0] cnt;
   logic [EFSR_DATA_W-1:0] fifo_q;
   logic [EFSR_DATA_W-1:0] tag_q;
   // test mode lets host push and pop either way to probe depth
   wire logic host_push = fifo_mode && wr_rise && (sel_d || sel_a)
      && (!direction_in || test_mode) && (cnt != EFSR_FULL_CNT);
   wire logic host_pop = fifo_mode && rd_fall && sel_d
      && (direction_in || test_mode) && (cnt != 5'h00);
   wire logic push = host_push || (fifo_mode && direction_in && eng_push_in
      && cnt != EFSR_FULL_CNT);
   wire logic pop = host_pop || (fifo_mode && !direction_in && eng_pop_in && cnt != 5'h00);
   wire logic [EFSR_DATA_W-1:0] push_data = host_push ? wdata_s_r : eng_data_in;
   // fifo flushed and held empty outside fifo modes
   efsr_fifo_mem u_fifo (
      .sys_clk_in(sys_clk_in),
      .rst_b_in(rst_b_in),
      .flush_in(!fifo_mode),
      .push_in(push),
      .wdata_in(push_data),
      .pop_in(pop),
      .rdata_out(fifo_q),
      .count_out(cnt)
   );
   // address-tag side fifo: bit 0 marks address/rle bytes
   efsr_fifo_mem u_tag (
      .sys_clk_in(sys_clk_in),
      .rst_b_in(rst_b_in),
      .flush_in(!fifo_mode),
      .push_in(push),
      .wdata_in({7'h00, host_push && sel_a}),
      .pop_in(pop),
      .rdata_out(tag_q),
      .count_out()
   );
   // ------------------------------------------------------------
   // read data and engine outputs
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         host_rdata_out <= 8'h00;
         host_rdata_oe_n_out <= 1'b1;
         eng_data_out <= 8'h00;
         eng_is_addr_out <= 1'b0;
         fifo_count_out <= 5'h00;
      end
      else
      begin
         if (host_pop)
            host_rdata_out <= fifo_q;
         host_rdata_oe_n_out <= !(!ior_n_s && sel_d && fifo_mode);
         eng_data_out <= fifo_q;
         eng_is_addr_out <= tag_q[0] && cnt != 5'h00;
         fifo_count_out <= cnt;
      end
   end
   // ------------------------------------------------------------
   // thresholds
   // ------------------------------------------------------------
   // field is threshold-1; 16 collapses to 15
   wire logic [4:0] thr_raw = {1'b0, threshold_field_in} + 5'h01;
   wire logic [4:0] thr = (thr_raw > EFSR_THR_CAP) ? EFSR_THR_CAP : thr_raw;
   wire logic [4:0] rev_need = EFSR_FULL_CNT - thr;
   wire logic rev_cond = direction_in && (cnt >= rev_need);
   wire logic fwd_cond = !direction_in && (cnt <= thr);
   wire logic pio_cond = fifo_mode && !dma_enable_bit_in && !service_interrupt_mask_in
      && (rev_cond || fwd_cond);
   // ------------------------------------------------------------
   // dma request
   // ------------------------------------------------------------
   efsr_drq_t drq_r;
   logic [5:0] burst_r;
   logic [5:0] gap_r;
   wire logic dma_data = direction_in ? (cnt != 5'h00) : (cnt != EFSR_FULL_CNT);
   wire logic tc_hit = tc_s && dma_cyc;
   wire logic last_byte = direction_in && cnt == 5'h01 && (dack_fall || (dma_cyc && rd_fall));
   // mask must be seen set, then cleared, before a tc drop may end
   logic tc_mask_seen_r;
   always_ff @(posedge sys_clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
         tc_mask_seen_r <= 1'b0;
      else if (drq_r != EFSR_DRQ_TC)
         tc_mask_seen_r <= 1'b0;
      else if (service_interrupt_mask_in)
         tc_mask_seen_r <= 1'b1;
   end
   always_ff @(posedge sys_clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         drq_r <= EFSR_DRQ_IDLE;
         burst_r <= 6'h00;
         gap_r <= 6'h00;
      end
      else
      begin
         unique case (drq_r)
            EFSR_DRQ_IDLE:
            begin
               burst_r <= 6'h00;
               // empty-drop returns with one byte
               if (dma_ok && !service_interrupt_mask_in && dma_data)
                  drq_r <= EFSR_DRQ_ON;
            end
            EFSR_DRQ_ON:
            begin
               if (dack_fall)
                  burst_r <= burst_r + 6'h01;
               if (tc_hit)
                  drq_r <= EFSR_DRQ_TC;
               else if (!dma_ok || service_interrupt_mask_in || !dma_data || last_byte)
                  drq_r <= EFSR_DRQ_IDLE;
               else if (dack_fall && burst_r == 6'(BURST_MAX - 1))
               begin
                  drq_r <= EFSR_DRQ_HOLD;
                  gap_r <= 6'h00;
               end
            end
            EFSR_DRQ_HOLD:
            begin
               // gap counts only while acknowledge is released
               if (dma_cyc)
                  gap_r <= 6'h00;
               else if (gap_r == 6'(GAP_CYC - 1))
                  drq_r <= EFSR_DRQ_IDLE;
               else
                  gap_r <= gap_r + 6'h01;
            end
            EFSR_DRQ_TC:
            begin
               // waits for mask to be set and cleared again
               if (tc_mask_seen_r && !service_interrupt_mask_in && !tc_s)
                  drq_r <= EFSR_DRQ_IDLE;
            end
         endcase
      end
   end
   always_ff @(posedge sys_clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
         port_dma_request_out <= 1'b0;
      else
         port_dma_request_out <= (drq_r == EFSR_DRQ_ON) && !tc_hit && !last_byte
            && dma_ok && !service_interrupt_mask_in && dma_data;
   end
   // ------------------------------------------------------------
   // interrupt pulse and mask set
   // ------------------------------------------------------------
   logic tc_s_d_r;
   logic pio_d_r;
   logic [2:0] pulse_r;
   wire logic tc_evt = tc_hit && !tc_s_d_r && dma_ok && !service_interrupt_mask_in;
   wire logic pio_evt = pio_cond && !pio_d_r;
   always_ff @(posedge sys_clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         tc_s_d_r <= 1'b0;
         pio_d_r <= 1'b0;
         pulse_r <= 3'h0;
         service_interrupt_set_out <= 1'b0;
         port_irq_line_out <= 1'b1;
         port_irq_line_oe_n_out <= 1'b1;
      end
      else
      begin
         tc_s_d_r <= tc_hit;
         pio_d_r <= pio_cond;
         // terminal count sets the mask through service_interrupt_set_out
         service_interrupt_set_out <= tc_evt;
         if (tc_evt || pio_evt)
            pulse_r <= 3'(EFSR_IRQ_PULSE_CYC);
         else if (pulse_r != 3'h0)
            pulse_r <= pulse_r - 3'h1;
         // drive low briefly then float for sharing
         port_irq_line_out <= 1'b0;
         port_irq_line_oe_n_out <= !(tc_evt || pio_evt || pulse_r > 3'h1);
      end
   end
   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   burst_cap_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
      burst_r <= 6'(BURST_MAX)) else $error("burst count exceeded");
   tc_drop_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
      tc_hit |=> !port_dma_request_out) else $error("request held after tc");
   tc_irq_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
      tc_evt |=> service_interrupt_set_out && !port_irq_line_oe_n_out)
      else $error("tc without interrupt");
   mask_block_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
      service_interrupt_mask_in && $stable(service_interrupt_mask_in) |=> !port_dma_request_out)
      else $error("request while masked");
   reset_empty_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
      !fifo_mode |=> cnt == 5'h00) else $error("fifo live outside mode");
   cnt_range_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
      cnt <= EFSR_FULL_CNT) else $error("count above depth");
   thr_cap_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
      threshold_field_in == 4'hF |-> thr == EFSR_THR_CAP) else $error("threshold not capped");
   irq_pulse_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
      !port_irq_line_oe_n_out [*5] |-> 1'b0) else $error("irq pulse too long");
   hold_gap_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
      drq_r == EFSR_DRQ_HOLD |=> !port_dma_request_out) else $error("request in gap");
   tc_wait_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
      drq_r == EFSR_DRQ_TC && !tc_mask_seen_r |=> !port_dma_request_out)
      else $error("request before mask cycled");
   dma_cov_c: cover property (@(posedge sys_clk_in) drq_r == EFSR_DRQ_HOLD);
   tc_cov_c: cover property (@(posedge sys_clk_in) tc_evt);
   pio_cov_c: cover property (@(posedge sys_clk_in) pio_evt && direction_in);
endmodule : efsr_top
`default_nettype wire

// file: include/efsr_pkg.sv
// package for the parallel-port fifo service-request block
// assumes a 40 MHz device clock and an isa-style host bus on pins
package efsr_pkg;
   // ------------------------------------------------------------
   // addresses and widths
   // ------------------------------------------------------------
   localparam int EFSR_ADDR_W = 11;
   localparam logic [10:0] EFSR_AFIFO_OFS = 11'h000;
   localparam logic [10:0] EFSR_DFIFO_OFS = 11'h400;
   localparam int EFSR_DATA_W = 8;
   localparam int EFSR_DEPTH = 16;
   localparam int EFSR_CNT_W = 5;
   localparam logic [4:0] EFSR_FULL_CNT = 5'h10;
   localparam logic [4:0] EFSR_THR_CAP = 5'h0F;
   // ------------------------------------------------------------
   // port modes
   // ------------------------------------------------------------
   localparam logic [2:0] EFSR_MODE_COMPATIBLE_MODE_FIFO = 3'h2;
   localparam logic [2:0] EFSR_MODE_ECP = 3'h3;
   localparam logic [2:0] EFSR_MODE_TEST = 3'h6;
   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int EFSR_CLK_NS = 25;
   localparam int EFSR_DACK_GAP_NS = 350;
   localparam int EFSR_DACK_GAP_CYC = (EFSR_DACK_GAP_NS + EFSR_CLK_NS - 1) / EFSR_CLK_NS;
   localparam int EFSR_BURST_MAX = 32;
   localparam int EFSR_IRQ_PULSE_CYC = 4;
   typedef enum logic [1:0]
   {
      EFSR_DRQ_IDLE = 2'b00,
      EFSR_DRQ_ON = 2'b01,
      EFSR_DRQ_HOLD = 2'b10,
      EFSR_DRQ_TC = 2'b11
   } efsr_drq_t;
endpackage : efsr_pkg

// file: verification/efsr_host_dma.sv
// host dma controller model: reads the fifo under acknowledge
// assumes the bench ands our read strobe with its own
`timescale 1ns/100ps
`default_nettype none
module efsr_host_dma
(
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_b_in,
   // bench control
   input wire logic start_in,
   input wire logic [7:0] len_in,
   input wire logic slow_in,
   // isa side
   input wire logic port_dma_request_in,
   input wire logic [7:0] rdata_in,
   output logic dack_n_out,
   output logic ior_n_out,
   output logic tc_out,
   output logic got_out,
   output logic [7:0] got_data_out
);
   int left = 0;
   initial
   begin
      dack_n_out = 1'b1;
      ior_n_out = 1'b1;
      tc_out = 1'b0;
      got_out = 1'b0;
      got_data_out = 8'h00;
   end
   // one byte per request, terminal count only with the last one
   always
   begin
      @(posedge sys_clk_in);
      if (start_in)
         left = len_in;
      else if (rst_b_in && port_dma_request_in && left != 0)
      begin
         if (slow_in)
            repeat (8) @(posedge sys_clk_in);
         dack_n_out <= 1'b0;
         tc_out <= (left == 1);
         @(posedge sys_clk_in);
         ior_n_out <= 1'b0;
         repeat (6) @(posedge sys_clk_in);
         got_data_out <= rdata_in;
         got_out <= 1'b1;
         ior_n_out <= 1'b1;
         dack_n_out <= 1'b1;
         tc_out <= 1'b0;
         left = left - 1;
         @(posedge sys_clk_in);
         got_out <= 1'b0;
         repeat (3) @(posedge sys_clk_in);
      end
   end
endmodule : efsr_host_dma
`default_nettype wire

// file: verification/tb.sv
// bench for the fifo service-request block with a host dma model
// assumes short burst and gap parameters to keep the run brief
`timescale 1ns/100ps
`default_nettype none
module tb
   import efsr_pkg::*;
;
   localparam int BM = 4;
   localparam int GAP = 2;
   logic sys_clk_in = 1'b0;
   logic rst_b_in = 1'b0;
   logic [10:0] addr = 11'h000;
   logic ior_n = 1'b1, iow_n = 1'b1, dir = 1'b0, dma_enable_bit = 1'b0, mask = 1'b1;
   logic [7:0] wdata = 8'h00, eng_d = 8'h00, rdata, eng_q, got_d, dlen = 8'h00, x, r;
   logic [2:0] mode = 3'h0;
   logic [3:0] thr = 4'h0;
   logic pop = 1'b0, push = 1'b0, start = 1'b0, slow = 1'b0;
   logic oe_n, drq, irq, irq_oe_n, svc, eng_a, dack_n, dior_n, tc, got;
   logic [4:0] cnt;
   logic irq_prev = 1'b1, dack_prev = 1'b1;
   int error_cnt = 0, tests_run = 0, cyc = 0, irq_cnt = 0, svc_cnt = 0;
   int got_cnt = 0, burst = 0, low_run = 0, c, n, g, eff;
   logic [7:0] q[$];
   always #12.5 sys_clk_in = ~sys_clk_in;
   efsr_top #(.BURST_MAX(BM), .GAP_CYC(GAP)) u_efsr_top (.sys_clk_in(sys_clk_in),
      .rst_b_in(rst_b_in), .host_addr_in(addr), .host_ior_n_in(ior_n & dior_n),
      .host_iow_n_in(iow_n), .host_wdata_in(wdata), .host_rdata_out(rdata),
      .host_rdata_oe_n_out(oe_n), .port_dma_acknowledge_n_in(dack_n), .host_tc_in(tc),
      .port_dma_request_out(drq), .port_irq_line_out(irq), .port_irq_line_oe_n_out(irq_oe_n),
      .port_mode_in(mode), .direction_in(dir), .dma_enable_bit_in(dma_enable_bit),
      .service_interrupt_mask_in(mask), .threshold_field_in(thr),
      .service_interrupt_set_out(svc), .fifo_count_out(cnt), .eng_pop_in(pop),
      .eng_data_out(eng_q), .eng_is_addr_out(eng_a), .eng_push_in(push), .eng_data_in(eng_d));
   efsr_host_dma u_efsr_host_dma (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
      .start_in(start), .len_in(dlen), .slow_in(slow), .port_dma_request_in(drq),
      .rdata_in(rdata), .dack_n_out(dack_n), .ior_n_out(dior_n), .tc_out(tc),
      .got_out(got), .got_data_out(got_d));
   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      tests_run++;
      if (s !== e)
      begin
         error_cnt++;
         $display("FAIL %0t seen %h expected %h", $time, s, e);
      end
   endtask : chk
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : report_and_stop
   task automatic io_wr(input logic [10:0] a, input logic [7:0] d);
      @(posedge sys_clk_in);
      addr <= a;
      wdata <= d;
      iow_n <= 1'b0;
      repeat (4) @(posedge sys_clk_in);
      iow_n <= 1'b1;
      repeat (5) @(posedge sys_clk_in);
   endtask : io_wr
   task automatic io_rd(output logic [7:0] d);
      @(posedge sys_clk_in);
      addr <= 11'h400;
      ior_n <= 1'b0;
      repeat (6) @(posedge sys_clk_in);
      d = rdata;
      chk(8'(oe_n), 8'h00);
      ior_n <= 1'b1;
      repeat (5) @(posedge sys_clk_in);
      chk(8'(oe_n), 8'h01);
   endtask : io_rd
   task automatic pushb(input logic [7:0] d);
      @(posedge sys_clk_in);
      push <= 1'b1;
      eng_d <= d;
      q.push_back(d);
      @(posedge sys_clk_in);
      push <= 1'b0;
   endtask : pushb
   task automatic setm(input logic [2:0] m, input logic d, input logic e, input logic k);
      @(posedge sys_clk_in);
      mode <= m;
      dir <= d;
      dma_enable_bit <= e;
      mask <= k;
      repeat (6) @(posedge sys_clk_in);
   endtask : setm
   task automatic dma(input int len);
      @(posedge sys_clk_in);
      addr <= 11'(11'h123 + $urandom_range(200));
      slow <= 1'($urandom);
      start <= 1'b1;
      dlen <= 8'(len);
      @(posedge sys_clk_in);
      start <= 1'b0;
   endtask : dma
   task automatic wait_got(input int t);
      int k;
      k = 0;
      while (got_cnt < t && k < 3000)
      begin
         @(posedge sys_clk_in);
         k++;
      end
      repeat (6) @(posedge sys_clk_in);
   endtask : wait_got
   // ------------------------------------------------------------
   // monitors
   // ------------------------------------------------------------
   always @(posedge sys_clk_in)
   begin
      cyc++;
      if (cyc > 60000)
      begin
         error_cnt++;
         report_and_stop();
      end
      irq_prev <= irq_oe_n;
      if (irq_prev && !irq_oe_n)
      begin
         irq_cnt++;
         chk(8'(irq), 8'h00);
      end
      if (svc)
         svc_cnt++;
      if (got)
      begin
         got_cnt++;
         chk(got_d, q.pop_front());
      end
      dack_prev <= dack_n;
      if (dack_prev && !dack_n)
         burst++;
      low_run <= (!drq && dack_n) ? low_run + 1 : 0;
      if (low_run >= GAP)
         burst = 0;
      if (burst > BM)
         chk(8'(burst), 8'(BM));
   end
   // ------------------------------------------------------------
   // sequence
   // ------------------------------------------------------------
   initial
   begin
      void'($urandom(49974));
      repeat (16) @(posedge sys_clk_in);
      rst_b_in <= 1'b1;
      repeat (4) @(posedge sys_clk_in);
      chk(8'(drq), 8'h00);
      chk(8'(irq_oe_n), 8'h01);
      chk(8'(cnt), 8'h00);
      for (int f = 0; f < 16; f++)
      begin
         eff = (f + 1 > 15) ? 15 : f + 1;
         thr <= 4'(f);
         for (int d = 0; d < 2; d++)
         begin
            c = $urandom_range(16);
            setm(3'h0, d[0], 1'b0, 1'b1);
            q.delete();
            chk(8'(cnt), 8'h00);
            setm(EFSR_MODE_ECP, d[0], 1'b0, 1'b1);
            n = irq_cnt;
            for (int i = 0; i < c; i++)
               if (d == 1)
                  pushb(8'($urandom));
               else
                  io_wr(EFSR_DFIFO_OFS, 8'($urandom));
            repeat (6) @(posedge sys_clk_in);
            chk(8'(cnt), 8'(c));
            chk(8'(irq_cnt != n), 8'h00);
            setm(EFSR_MODE_ECP, d[0], 1'b0, 1'b0);
            repeat (6) @(posedge sys_clk_in);
            if (d == 1)
               chk(8'(irq_cnt != n), 8'(c >= 16 - eff));
            else
               chk(8'(irq_cnt != n), 8'(c <= eff));
         end
      end
      setm(EFSR_MODE_ECP, 1'b1, 1'b0, 1'b1);
      while (q.size() < 16)
         pushb(8'($urandom)); // full, so a whole drain is allowed
      for (int i = 0; i < 3; i++)
      begin
         x = q.pop_front();
         io_rd(r);
         chk(r, x);
      end
      setm(3'h0, 1'b0, 1'b0, 1'b1);
      q.delete();
      setm(EFSR_MODE_ECP, 1'b0, 1'b0, 1'b1);
      x = 8'($urandom);
      io_wr(EFSR_AFIFO_OFS, x);
      io_wr(EFSR_DFIFO_OFS, ~x);
      chk(8'(eng_a), 8'h01);
      chk(eng_q, x);
      @(posedge sys_clk_in);
      pop <= 1'b1;
      @(posedge sys_clk_in);
      pop <= 1'b0;
      repeat (4) @(posedge sys_clk_in);
      chk(8'(eng_a), 8'h00);
      chk(eng_q, ~x);
      setm(3'h0, 1'b0, 1'b0, 1'b1);
      setm(EFSR_MODE_TEST, 1'b0, 1'b0, 1'b1);
      io_wr(EFSR_DFIFO_OFS, x);
      chk(8'(cnt), 8'h01);
      io_rd(r);
      chk(r, x);
      setm(3'h0, 1'b1, 1'b0, 1'b1);
      setm(EFSR_MODE_ECP, 1'b1, 1'b0, 1'b1);
      for (int i = 0; i < 5; i++)
         pushb(8'($urandom));
      g = got_cnt;
      n = irq_cnt;
      c = svc_cnt;
      dma(5);
      setm(EFSR_MODE_ECP, 1'b1, 1'b1, 1'b0);
      wait_got(g + 5);
      chk(8'(got_cnt - g), 8'h05);
      chk(8'(drq), 8'h00);
      chk(8'(svc_cnt != c), 8'h01);
      chk(8'(irq_cnt != n), 8'h01);
      pushb(8'($urandom));
      pushb(8'($urandom));
      repeat (10) @(posedge sys_clk_in);
      chk(8'(drq), 8'h00);
      setm(EFSR_MODE_ECP, 1'b1, 1'b1, 1'b1);
      dma(2);
      setm(EFSR_MODE_ECP, 1'b1, 1'b1, 1'b0);
      wait_got(g + 7);
      chk(8'(got_cnt - g), 8'h07);
      setm(EFSR_MODE_ECP, 1'b1, 1'b1, 1'b1);
      dma(8);
      setm(EFSR_MODE_ECP, 1'b1, 1'b1, 1'b0);
      for (int i = 0; i < 3; i++)
         pushb(8'($urandom));
      wait_got(g + 10);
      chk(8'(drq), 8'h00);
      chk(8'(cnt), 8'h00);
      pushb(8'($urandom));
      wait_got(g + 11);
      chk(8'(got_cnt - g), 8'h0B);
      for (int i = 0; i < 4; i++)
         pushb(8'($urandom));
      wait_got(g + 15);
      setm(EFSR_MODE_ECP, 1'b1, 1'b1, 1'b1);
      for (int i = 0; i < 12; i++)
         pushb(8'($urandom));
      dma(12);
      setm(EFSR_MODE_ECP, 1'b1, 1'b1, 1'b0);
      wait_got(g + 27);
      chk(8'(got_cnt - g), 8'h1B);
      report_and_stop();
   end
endmodule : tb
`default_nettype wire
